// ===== rtl/rcas_defines.svh
/*
  register offsets, field positions, reset values and timing counts
  of the receiver configuration block; plain macro definitions only
*/
`ifndef RCAS_DEFINES_SVH
`define RCAS_DEFINES_SVH
// ------------------------------------------------------------
// register indices (byte address is four times the index)
// ------------------------------------------------------------
`define RCAS_IDX_SST     8'h06
`define RCAS_IDX_CFG1    8'h0b
`define RCAS_IDX_CFG2    8'h0c
`define RCAS_IDX_CTRL    8'h20
`define RCAS_IDX_STAT    8'h21
// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define RCAS_RST_SST     8'h00
`define RCAS_RST_CFG1    8'h00
`define RCAS_RST_CFG2    8'h2c
`define RCAS_RST_CTRL    16'h0000
// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define RCAS_SST_MSB     4
`define RCAS_C1_CHSEL    7
`define RCAS_C2_IQ       7
`define RCAS_C2_MIXER    6
`define RCAS_C2_SQDYN    5
`define RCAS_C2_SQ63     4
`define RCAS_C2_AGCEN    3
`define RCAS_C2_AGCM     2
`define RCAS_C2_AGCALG   1
`define RCAS_C2_AGC63    0
`define RCAS_CT_SINGLE   0
`define RCAS_CT_MANUAL   1
`define RCAS_CT_EMD      2
`define RCAS_CT_ISOB106  3
`define RCAS_ST_SOFTERR  0
`define RCAS_ST_RESTART  1
// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define RCAS_CLK_PERIOD_NS  10
`define RCAS_SQ_DELAY_NS    18880
`define RCAS_SQ_DELAY_CYC   ((`RCAS_SQ_DELAY_NS + `RCAS_CLK_PERIOD_NS - 1) / `RCAS_CLK_PERIOD_NS)
`endif

// ===== rtl/rcas_pkg.sv
/*
  types shared by the receiver configuration block
  assumes nothing beyond a SystemVerilog compiler
*/
package rcas_pkg;
   // ------------------------------------------------------------
   // settings handed to the analog front end
   // ------------------------------------------------------------
   typedef struct packed {
      logic       am_on;
      logic       pm_on;
      logic       framing_pm;
      logic       demod_iq;
      logic       amd_mixer;
      logic       squelch_ratio_63;
      logic       agc_on;
      logic       agc_full_period;
      logic       agc_alg_reset;
      logic       gain_trigger_ratio;
      logic [2:0] lowpass_code;
      logic [3:0] zero_setting;
   } rcas_fe_ctrl_t;

   // squelch sequencer
   typedef enum logic [1:0] {SQ_IDLE, SQ_WAIT, SQ_ACTIVE} rcas_sq_state_t;
endpackage

// ===== rtl/rcas_top.sv
/*
  receiver configuration, squelch and subcarrier start checks,
  reached over AXI4-Lite. assumes the receive decoder drives its
  event inputs as one-cycle pulses on aclk and that a quarter-etu
  tick comes from the same clock domain.
*/
`include "rcas_defines.svh"
`timescale 1ns/1ns
module rcas_top
   import rcas_pkg::*;
(
   // clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // axi4-lite write address and data
   input  wire logic        s_awvalid,
   output logic             s_awready,
   input  wire logic [9:0]  s_awaddr,
   input  wire logic        s_wvalid,
   output logic             s_wready,
   input  wire logic [31:0] s_wdata,
   input  wire logic [3:0]  s_wstrb,
   // axi4-lite write response
   output logic             s_bvalid,
   input  wire logic        s_bready,
   output logic [1:0]       s_bresp,
   // axi4-lite read
   input  wire logic        s_arvalid,
   output logic             s_arready,
   input  wire logic [9:0]  s_araddr,
   output logic             s_rvalid,
   input  wire logic        s_rready,
   output logic [31:0]      s_rdata,
   output logic [1:0]       s_rresp,
   // receive decoder events
   input  wire logic        tx_end,
   input  wire logic        mask_receive_timer_end,
   input  wire logic [7:0]  mask_receive_timer,
   input  wire logic        subcarrier_det,
   input  wire logic        quarter_etu_tick,
   input  wire logic        auto_framing_pm,
   // front end settings and actions
   output rcas_fe_ctrl_t    fe_ctrl,
   output logic             squelch_on,
   output logic             frame_discard,
   output logic             rx_restart
);
   // ------------------------------------------------------------
   // register storage
   // ------------------------------------------------------------
   logic [7:0]     sst_reg;
   logic [7:0]     cfg1_reg;
   logic [7:0]     cfg2_reg;
   logic [15:0]    ctrl_reg;
   logic [1:0]     stat_reg;
   logic [7:0]     aw_idx_reg;
   logic           aw_have_reg;
   logic [31:0]    wd_reg;
   logic [3:0]     ws_reg;
   logic           wd_have_reg;
   rcas_sq_state_t sq_state_reg;
   logic [10:0]    sq_cnt_reg;
   logic [4:0]     sst_cnt_reg;
   logic           sst_arm_reg;
   logic           early_det;
   logic           wr_fire;
   logic [1:0]     stat_clr;

   // byte address to register index
   function automatic logic [7:0] addr_idx(input logic [9:0] a);
      addr_idx = a[9:2];
   endfunction

   // index is one of the mapped registers
   function automatic logic idx_hit(input logic [7:0] i);
      idx_hit = (i == `RCAS_IDX_SST) || (i == `RCAS_IDX_CFG1) ||
                (i == `RCAS_IDX_CFG2) || (i == `RCAS_IDX_CTRL) ||
                (i == `RCAS_IDX_STAT);
   endfunction

   // ------------------------------------------------------------
   // axi write channels
   // ------------------------------------------------------------
   // address and data taken in either order, held until both exist
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_have_reg <= 1'b0;
         aw_idx_reg  <= 8'h00;
      end
      else if (s_awvalid && s_awready)
      begin
         aw_have_reg <= 1'b1;
         aw_idx_reg  <= addr_idx(s_awaddr);
      end
      else if (wr_fire)
         aw_have_reg <= 1'b0;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         wd_have_reg <= 1'b0;
         wd_reg      <= 32'h0000_0000;
         ws_reg      <= 4'h0;
      end
      else if (s_wvalid && s_wready)
      begin
         wd_have_reg <= 1'b1;
         wd_reg      <= s_wdata;
         ws_reg      <= s_wstrb;
      end
      else if (wr_fire)
         wd_have_reg <= 1'b0;
   end

   // commit once both halves are held and no response is pending
   assign wr_fire = aw_have_reg && wd_have_reg && !s_bvalid;

   // ready drops while a half is held, so one write at a time
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_awready <= 1'b0;
         s_wready  <= 1'b0;
      end
      else
      begin
         s_awready <= !aw_have_reg && !(s_awvalid && s_awready) && !wr_fire;
         s_wready  <= !wd_have_reg && !(s_wvalid && s_wready) && !wr_fire;
      end
   end

   // response: unmapped index answers slverr
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_bvalid <= 1'b0;
         s_bresp  <= 2'b00;
      end
      else if (wr_fire)
      begin
         s_bvalid <= 1'b1;
         s_bresp  <= idx_hit(aw_idx_reg) ? 2'b00 : 2'b10;
      end
      else if (s_bready)
         s_bvalid <= 1'b0;
   end

   // ------------------------------------------------------------
   // configuration registers
   // ------------------------------------------------------------
   // only lane 0 carries the 8-bit registers; reserved bits stay zero
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sst_reg  <= `RCAS_RST_SST;
         cfg1_reg <= `RCAS_RST_CFG1;
         cfg2_reg <= `RCAS_RST_CFG2;
      end
      else if (wr_fire && ws_reg[0])
      begin
         if (aw_idx_reg == `RCAS_IDX_SST)
            sst_reg <= {3'b000, wd_reg[`RCAS_SST_MSB:0]};
         if (aw_idx_reg == `RCAS_IDX_CFG1)
            cfg1_reg <= wd_reg[7:0];
         if (aw_idx_reg == `RCAS_IDX_CFG2)
            cfg2_reg <= wd_reg[7:0];
      end
   end

   // control: low byte mode bits, high byte squelch end time
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         ctrl_reg <= `RCAS_RST_CTRL;
      else if (wr_fire && aw_idx_reg == `RCAS_IDX_CTRL)
      begin
         if (ws_reg[0])
            ctrl_reg[7:0] <= {4'h0, wd_reg[3:0]};
         if (ws_reg[1])
            ctrl_reg[15:8] <= wd_reg[15:8];
      end
   end

   // write-one-to-clear mask for the cause bits
   assign stat_clr = (wr_fire && ws_reg[0] && aw_idx_reg == `RCAS_IDX_STAT)
                     ? wd_reg[1:0] : 2'b00;

   // ------------------------------------------------------------
   // axi read channel
   // ------------------------------------------------------------
   // answer one cycle after the address is taken
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_arready <= 1'b0;
         s_rvalid  <= 1'b0;
         s_rdata   <= 32'h0000_0000;
         s_rresp   <= 2'b00;
      end
      else if (s_arvalid && s_arready)
      begin
         s_arready <= 1'b0;
         s_rvalid  <= 1'b1;
         s_rresp   <= idx_hit(addr_idx(s_araddr)) ? 2'b00 : 2'b10;
         unique case (addr_idx(s_araddr))
            `RCAS_IDX_SST:  s_rdata <= {24'h000000, sst_reg};
            `RCAS_IDX_CFG1: s_rdata <= {24'h000000, cfg1_reg};
            `RCAS_IDX_CFG2: s_rdata <= {24'h000000, cfg2_reg};
            `RCAS_IDX_CTRL: s_rdata <= {16'h0000, ctrl_reg};
            `RCAS_IDX_STAT: s_rdata <= {30'h00000000, stat_reg};
            default:        s_rdata <= 32'h0000_0000;
         endcase
      end
      else if (s_rvalid)
      begin
         if (s_rready)
         begin
            s_rvalid  <= 1'b0;
            s_arready <= 1'b1;
         end
      end
      else
         s_arready <= 1'b1;
   end

   // ------------------------------------------------------------
   // subcarrier start check
   // ------------------------------------------------------------
   // quarter-etu count from the end of the mask receive timer
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sst_arm_reg <= 1'b0;
         sst_cnt_reg <= 5'h00;
      end
      else if (mask_receive_timer_end)
      begin
         sst_arm_reg <= ctrl_reg[`RCAS_CT_ISOB106];
         sst_cnt_reg <= 5'h00;
      end
      else if (subcarrier_det || (sst_cnt_reg >= sst_reg[4:0]))
         sst_arm_reg <= 1'b0;
      else if (sst_arm_reg && quarter_etu_tick)
         sst_cnt_reg <= sst_cnt_reg + 5'h01;
   end

   // detection before the programmed time has elapsed
   assign early_det = sst_arm_reg && subcarrier_det &&
                      (sst_cnt_reg < sst_reg[4:0]);

   // sticky causes; a new event wins over a clear in the same cycle
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         stat_reg <= 2'b00;
      else
      begin
         stat_reg[`RCAS_ST_SOFTERR] <= early_det ||
            (stat_reg[`RCAS_ST_SOFTERR] && !stat_clr[0]);
         stat_reg[`RCAS_ST_RESTART] <= (early_det && ctrl_reg[`RCAS_CT_EMD]) ||
            (stat_reg[`RCAS_ST_RESTART] && !stat_clr[1]);
      end
   end

   // emd: drop the frame and restart reception
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         frame_discard <= 1'b0;
         rx_restart    <= 1'b0;
      end
      else
      begin
         frame_discard <= early_det && ctrl_reg[`RCAS_CT_EMD];
         rx_restart    <= early_det && ctrl_reg[`RCAS_CT_EMD];
      end
   end

   // ------------------------------------------------------------
   // dynamic squelch
   // ------------------------------------------------------------
   // a fresh tx end restarts the delay; clearing the enable stops all
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sq_state_reg <= SQ_IDLE;
         sq_cnt_reg   <= 11'h000;
         squelch_on   <= 1'b0;
      end
      else if (!cfg2_reg[`RCAS_C2_SQDYN])
      begin
         sq_state_reg <= SQ_IDLE;
         squelch_on   <= 1'b0;
      end
      else if (tx_end)
      begin
         sq_state_reg <= SQ_WAIT;
         sq_cnt_reg   <= 11'h001;
         squelch_on   <= 1'b0;
      end
      else
      begin
         unique case (sq_state_reg)
            SQ_IDLE: squelch_on <= 1'b0;
            SQ_WAIT:
            begin
               sq_cnt_reg <= sq_cnt_reg + 11'h001;
               if (sq_cnt_reg == 11'(`RCAS_SQ_DELAY_CYC))
               begin
                  sq_state_reg <= SQ_ACTIVE;
                  squelch_on   <= 1'b1;
               end
            end
            SQ_ACTIVE:
            begin
               if (mask_receive_timer >= ctrl_reg[15:8])
               begin
                  sq_state_reg <= SQ_IDLE;
                  squelch_on   <= 1'b0;
               end
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // front end settings
   // ------------------------------------------------------------
   // registered so every setting leaves from a flip-flop
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         fe_ctrl <= '0;
      else
      begin
         // single channel: select bit picks it; else both run
         fe_ctrl.am_on <= !ctrl_reg[`RCAS_CT_SINGLE] ||
                          !cfg1_reg[`RCAS_C1_CHSEL];
         fe_ctrl.pm_on <= !ctrl_reg[`RCAS_CT_SINGLE] ||
                          cfg1_reg[`RCAS_C1_CHSEL];
         if (ctrl_reg[`RCAS_CT_SINGLE] || ctrl_reg[`RCAS_CT_MANUAL])
            fe_ctrl.framing_pm <= cfg1_reg[`RCAS_C1_CHSEL];
         else
            fe_ctrl.framing_pm <= auto_framing_pm;
         fe_ctrl.demod_iq <= cfg2_reg[`RCAS_C2_IQ];
         // i/q cannot run on the peak detector, so mixer is forced
         fe_ctrl.amd_mixer <= cfg2_reg[`RCAS_C2_MIXER] ||
                              cfg2_reg[`RCAS_C2_IQ];
         fe_ctrl.squelch_ratio_63   <= cfg2_reg[`RCAS_C2_SQ63];
         fe_ctrl.agc_on             <= cfg2_reg[`RCAS_C2_AGCEN];
         fe_ctrl.agc_full_period    <= cfg2_reg[`RCAS_C2_AGCM];
         fe_ctrl.agc_alg_reset      <= cfg2_reg[`RCAS_C2_AGCALG];
         fe_ctrl.gain_trigger_ratio <= cfg2_reg[`RCAS_C2_AGC63];
         fe_ctrl.lowpass_code       <= cfg1_reg[6:4];
         fe_ctrl.zero_setting       <= cfg1_reg[3:0];
      end
   end
endmodule

// ===== tb/rcas_fe_model.sv
/*
  model of the receive decoder in front of the block
  assumes aclk domain; events are one-cycle pulses
*/
`timescale 1ns/1ns
module rcas_fe_model
(
   // clock
   input wire logic  aclk,
   // decoder events
   output logic       tx_end,
   output logic       mask_receive_timer_end,
   output logic [7:0] mask_receive_timer,
   output logic       subcarrier_det,
   output logic       quarter_etu_tick,
   output logic       auto_framing_pm
);
   // ------------------------------------------------------------
   // timers and events
   // ------------------------------------------------------------
   logic [4:0] div_reg;
   logic [1:0] q_reg;

   initial
   begin
      {tx_end, mask_receive_timer_end, subcarrier_det, auto_framing_pm} = 4'h0;
      mask_receive_timer = 8'h00;
      div_reg = 5'h00;
      q_reg = 2'h0;
      quarter_etu_tick = 1'b0;
   end

   // timer restarts at tx end, one step per 32 cycles keeps the window wide
   always @(posedge aclk)
   begin
      div_reg <= tx_end ? 5'h00 : div_reg + 5'h01;
      if (tx_end)
         mask_receive_timer <= 8'h00;
      else if (div_reg == 5'h1f && mask_receive_timer != 8'hff)
         mask_receive_timer <= mask_receive_timer + 8'h01;
   end

   // quarter etu tick every fourth cycle
   always @(posedge aclk)
   begin
      q_reg <= q_reg + 2'h1;
      quarter_etu_tick <= (q_reg == 2'h3);
   end

   // one-cycle pulse: 0 tx end, 1 timer end, else detection
   // only the pulsed line is lowered, so a back-to-back call may raise another
   task automatic ev(input int k);
      case (k)
         0: tx_end <= 1'b1;
         1: mask_receive_timer_end <= 1'b1;
         default: subcarrier_det <= 1'b1;
      endcase
      @(posedge aclk);
      case (k)
         0: tx_end <= 1'b0;
         1: mask_receive_timer_end <= 1'b0;
         default: subcarrier_det <= 1'b0;
      endcase
   endtask
endmodule

// ===== tb/rcas_top_asserts.sv
/*
  port checker for rcas_top, bound to every instance
  assumes one clock aclk and a synchronous active-low reset
*/
`timescale 1ns/1ns
module rcas_top_asserts
   import rcas_pkg::*;
(
   // clock and reset
   input wire logic        aclk,
   input wire logic        aresetn,
   // bus answers
   input wire logic        s_bvalid,
   input wire logic        s_bready,
   input wire logic [1:0]  s_bresp,
   input wire logic        s_rvalid,
   input wire logic        s_rready,
   input wire logic [31:0] s_rdata,
   // receive side
   input wire logic        tx_end,
   input wire logic        subcarrier_det,
   input rcas_fe_ctrl_t    fe_ctrl,
   input wire logic        squelch_on,
   input wire logic        frame_discard,
   input wire logic        rx_restart
);
   // ------------------------------------------------------------
   // helper count and properties
   // ------------------------------------------------------------
   logic [11:0] since_tx;

   // saturates so that a stale tx_end never aliases a new one
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         since_tx <= 12'hfff;
      else if (tx_end)
         since_tx <= 12'h001;
      else if (since_tx != 12'hfff)
         since_tx <= since_tx + 12'h001;
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   AST_SQ_RISE: assert property ($rose(squelch_on) |-> since_tx inside {[1888:1891]})
      else $error("squelch rose at wrong delay");
   AST_SQ_RETRIG: assert property (tx_end |-> ##2 !squelch_on)
      else $error("squelch kept over new tx end");
   AST_B_HOLD: assert property (s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
      else $error("write answer dropped");
   AST_R_HOLD: assert property (s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
      else $error("read answer dropped");
   AST_EMD_PAIR: assert property (frame_discard == rx_restart)
      else $error("discard without restart");
   AST_EMD_PULSE: assert property (frame_discard |=> !frame_discard)
      else $error("discard longer than one cycle");
   AST_EMD_CAUSE: assert property (frame_discard |-> $past(subcarrier_det))
      else $error("discard without detection");
   AST_IQ_MIXER: assert property (fe_ctrl.demod_iq |-> fe_ctrl.amd_mixer)
      else $error("iq without mixer");
   AST_ONE_CHAN: assert property (fe_ctrl.am_on != fe_ctrl.pm_on
      |-> fe_ctrl.framing_pm == fe_ctrl.pm_on)
      else $error("single channel framing mismatch");
endmodule

bind rcas_top rcas_top_asserts u_rcas_top_asserts (.aclk, .aresetn, .s_bvalid, .s_bready,
   .s_bresp, .s_rvalid, .s_rready, .s_rdata, .tx_end, .subcarrier_det, .fe_ctrl,
   .squelch_on, .frame_discard, .rx_restart);

// ===== tb/tb_rcas_top.sv
/*
  self-checking bench of rcas_top with the decoder model
  assumes a 100 MHz aclk and the register map of the block
*/
`timescale 1ns/1ns
`include "rcas_defines.svh"
module tb_rcas_top
   import rcas_pkg::*;
;
   // ------------------------------------------------------------
   // signals, instances and helpers
   // ------------------------------------------------------------
   localparam logic [9:0] A_SST = {`RCAS_IDX_SST, 2'b00};
   localparam logic [9:0] A_C1  = {`RCAS_IDX_CFG1, 2'b00};
   localparam logic [9:0] A_C2  = {`RCAS_IDX_CFG2, 2'b00};
   localparam logic [9:0] A_CT  = {`RCAS_IDX_CTRL, 2'b00};
   localparam logic [9:0] A_ST  = {`RCAS_IDX_STAT, 2'b00};
   logic          aclk, aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready;
   logic          s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
   logic [9:0]    s_awaddr, s_araddr;
   logic [31:0]   s_wdata, s_rdata, rv;
   logic [3:0]    s_wstrb;
   logic [1:0]    s_bresp, s_rresp, ct;
   logic [7:0]    mask_receive_timer, c1, c2;
   logic          tx_end, mask_receive_timer_end, subcarrier_det, quarter_etu_tick;
   logic          auto_framing_pm, squelch_on, frame_discard, rx_restart, au;
   rcas_fe_ctrl_t fe_ctrl;
   int            err_count, cmp_count, n_disc, n_rst, sq_n, i, n, nd, nr, seed;
   int            ev_sst [5] = '{4, 4, 4, 4, 0};
   int            ev_ct [5]  = '{12, 8, 8, 4, 12};
   int            ev_dly [5] = '{0, 0, 40, 0, 0};
   int            ev_st [5]  = '{3, 1, 0, 0, 0};

   rcas_top u_rcas_top (.aclk, .aresetn, .s_awvalid, .s_awready, .s_awaddr, .s_wvalid,
      .s_wready, .s_wdata, .s_wstrb, .s_bvalid, .s_bready, .s_bresp, .s_arvalid,
      .s_arready, .s_araddr, .s_rvalid, .s_rready, .s_rdata, .s_rresp, .tx_end,
      .mask_receive_timer_end, .mask_receive_timer, .subcarrier_det, .quarter_etu_tick,
      .auto_framing_pm, .fe_ctrl, .squelch_on, .frame_discard, .rx_restart);
   rcas_fe_model u_rcas_fe_model (.aclk, .tx_end, .mask_receive_timer_end,
      .mask_receive_timer, .subcarrier_det, .quarter_etu_tick, .auto_framing_pm);

   initial
   begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   // event counts seen at the output pins
   always @(posedge aclk)
   begin
      n_disc += (frame_discard === 1'b1);
      n_rst += (rx_restart === 1'b1);
      sq_n += (squelch_on === 1'b1);
   end

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      cmp_count++;
      if (s !== e)
      begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask

   task automatic end_of_test();
      $display("compares %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // address and data offered together, each dropped once taken
   task automatic wr(input logic [9:0] a, input logic [31:0] d, input logic [1:0] er);
      s_awaddr <= a;
      s_wdata <= d;
      s_wstrb <= 4'hf;
      s_awvalid <= 1'b1;
      s_wvalid <= 1'b1;
      s_bready <= 1'b1;
      for (n = 0; n < 64; n++)
      begin
         @(posedge aclk);
         if (s_awvalid && s_awready)
            s_awvalid <= 1'b0;
         if (s_wvalid && s_wready)
            s_wvalid <= 1'b0;
         if (s_bvalid)
            break;
      end
      chk("bresp", er, s_bresp);
      s_bready <= 1'b0;
      @(posedge aclk);
   endtask

   task automatic rc(input logic [9:0] a, input logic [31:0] e, input logic [1:0] er);
      s_araddr <= a;
      s_arvalid <= 1'b1;
      s_rready <= 1'b1;
      for (n = 0; n < 64; n++)
      begin
         @(posedge aclk);
         if (s_arvalid && s_arready)
            s_arvalid <= 1'b0;
         if (s_rvalid)
            break;
      end
      chk("rdata", e, s_rdata);
      chk("rresp", er, s_rresp);
      s_rready <= 1'b0;
      @(posedge aclk);
   endtask

   function automatic rcas_fe_ctrl_t exp_fe(logic [7:0] r1, logic [7:0] r2, logic [1:0] m,
      logic a);
      rcas_fe_ctrl_t e;
      e = {r2[7], r2[7] | r2[6], r2[4], r2[3], r2[2], r2[1], r2[0], r1[6:0]};
      e.am_on = m[0] ? ~r1[7] : 1'b1;
      e.pm_on = m[0] ? r1[7] : 1'b1;
      e.framing_pm = (m[0] | m[1]) ? r1[7] : a;
      return e;
   endfunction

   initial
   begin
      #200000;
      err_count++;
      end_of_test();
   end

   initial
   begin
      seed = 32'h10535ed1;
      aresetn = 1'b0;
      {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 5'h00;
      {s_awaddr, s_araddr, s_wdata, s_wstrb} = '0;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      rc(A_SST, 32'h0, 2'b00);
      rc(A_C1, 32'h0, 2'b00);
      rc(A_C2, 32'h2c, 2'b00);
      rc(A_CT, 32'h0, 2'b00);
      chk("fe_ctrl", 32'(exp_fe(8'h00, 8'h2c, 2'b00, 1'b0)), 32'(fe_ctrl));
      $display("test reset done");
      // mode settings: iq without mixer first, then random
      for (i = 0; i < 16; i++)
      begin
         rv = $random(seed);
         c1 = rv[7:0];
         c2 = (i < 4) ? 8'h80 : rv[15:8];
         ct = i[1:0];
         au = rv[16];
         u_rcas_fe_model.auto_framing_pm <= au;
         wr(A_C1, {24'h0, c1}, 2'b00);
         wr(A_C2, {24'h0, c2}, 2'b00);
         wr(A_CT, {30'h0, ct}, 2'b00);
         chk("fe_ctrl", 32'(exp_fe(c1, c2, ct, au)), 32'(fe_ctrl));
         rc(A_C2, {24'h0, c2}, 2'b00);
      end
      $display("test settings done");
      wr(A_SST, 32'hff, 2'b00);
      rc(A_SST, 32'h1f, 2'b00);
      wr(10'h3fc, 32'h5a, 2'b10);
      rc(10'h3fc, 32'h0, 2'b10);
      $display("test map done");
      // early, late, unarmed and zero start time cases
      for (i = 0; i < 5; i++)
      begin
         wr(A_SST, ev_sst[i], 2'b00);
         wr(A_CT, ev_ct[i], 2'b00);
         nd = n_disc;
         nr = n_rst;
         u_rcas_fe_model.ev(1);
         repeat (ev_dly[i]) @(posedge aclk);
         u_rcas_fe_model.ev(2);
         repeat (3) @(posedge aclk);
         chk("discard", ev_st[i] >> 1, n_disc - nd);
         chk("restart", ev_st[i] >> 1, n_rst - nr);
         rc(A_ST, ev_st[i], 2'b00);
         wr(A_ST, 32'h3, 2'b00);
         rc(A_ST, 32'h0, 2'b00);
      end
      $display("test subcarrier done");
      wr(A_C2, 32'h2c, 2'b00);
      wr(A_CT, 32'h5000, 2'b00);
      u_rcas_fe_model.ev(0);
      for (n = 1; n < 3000 && squelch_on !== 1'b1; n++)
         @(posedge aclk);
      chk("sq_rise", 1, n >= 1889 && n <= 1891);
      for (n = 0; n < 4000 && squelch_on === 1'b1; n++)
         @(posedge aclk);
      chk("sq_stop", 32'h50, mask_receive_timer);
      wr(A_C2, 32'h0c, 2'b00);
      nd = sq_n;
      u_rcas_fe_model.ev(0);
      repeat (2100) @(posedge aclk);
      chk("sq_off", 0, sq_n - nd);
      $display("test squelch done");
      end_of_test();
   end
endmodule
